// [design/flash_command_state_machine.sv]
/*
 * Flash command interpreter: chip-wide write state machine, per-partition
 * output modes, status byte, block lock state and operation timers.
 * Assumes the array itself lives outside and answers array_addr_out
 * combinationally on array_data_in; address = {partition, block, offset}.
 */
`include "flash_cmd_params.svh"

module flash_command_state_machine #(
	parameter int PART_W       = 2,
	parameter int BLK_W        = 3,
	parameter int OFS_W        = 4,
	parameter int PROG_CYCLES  = `PROG_TIME_NS / `CLK_PERIOD_NS,
	parameter int ERASE_CYCLES = `ERASE_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
	parameter logic [15:0] MFR_ID = 16'h00a5,  // Arbitrary value
	parameter logic [15:0] DEV_ID = 16'h005a   // Arbitrary value
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	flash_bus_if.dev               bus,
	input  wire logic              vpp_ok_in,
	input  wire logic              erase_fail_in,
	input  wire logic [15:0]       array_data_in,
	output logic [PART_W+BLK_W+OFS_W-1:0] array_addr_out,
	output logic                   ready_out,
	output logic [PART_W-1:0]      active_part_out
);
	localparam int NPART = 1 << PART_W;
	localparam int NBLK  = 1 << (PART_W + BLK_W);
	localparam int AW    = PART_W + BLK_W + OFS_W;

	if (PART_W < 1 || BLK_W < 1 || OFS_W < 2 || PROG_CYCLES < 1 || ERASE_CYCLES < 1)
		$error("flash_command_state_machine: bad parameters");

	function automatic logic [PART_W-1:0] part_of(input logic [AW-1:0] a);
		return a[AW-1 -: PART_W];
	endfunction : part_of

	function automatic logic [PART_W+BLK_W-1:0] blk_of(input logic [AW-1:0] a);
		return a[AW-1 -: PART_W+BLK_W];
	endfunction : blk_of

	flash_cmd_pkg::wsm_state_t state_reg, state_next;
	flash_cmd_pkg::out_mode_t  mode_reg [NPART];
	logic [NBLK-1:0]           lock_reg, ldn_reg;
	logic [31:0]               pgm_cnt_reg, ers_cnt_reg;
	logic [7:0]                err_reg, set_err;
	logic [PART_W-1:0]         act_part_reg, ers_part_reg, busy_part;
	logic [PART_W+BLK_W-1:0]   efp_blk_reg, ers_blk_reg;
	logic [15:0]               rdata_reg;
	logic [7:0]                sr, cmd;
	logic [PART_W-1:0]         wpart;
	logic [PART_W+BLK_W-1:0]   wblk;
	logic                      wr, ld_pgm, ld_ers, ld_efp, pgm_run, ers_run;
	logic                      pgm_done, ers_done, busy, wlocked, lock_act;
	logic [7:0]                lock_cmd;

	assign wr      = bus.we;
	assign cmd     = bus.wdata[7:0];
	assign wpart   = part_of(bus.addr);
	assign wblk    = blk_of(bus.addr);
	assign wlocked = lock_reg[wblk];

	// ----------------------------------------
	// Status
	// ----------------------------------------
	always_comb begin
		busy = state_reg inside {flash_cmd_pkg::ST_PGM_BUSY, flash_cmd_pkg::ST_ERS_BUSY,
			flash_cmd_pkg::ST_PES_BUSY, flash_cmd_pkg::ST_OTP_BUSY,
			flash_cmd_pkg::ST_EFP_BUSY, flash_cmd_pkg::ST_EFP_VERIFY};
		pgm_run = state_reg inside {flash_cmd_pkg::ST_PGM_BUSY, flash_cmd_pkg::ST_PES_BUSY,
			flash_cmd_pkg::ST_OTP_BUSY, flash_cmd_pkg::ST_EFP_BUSY,
			flash_cmd_pkg::ST_EFP_VERIFY} && pgm_cnt_reg != 32'h0;
		ers_run = state_reg == flash_cmd_pkg::ST_ERS_BUSY;
		sr = err_reg;
		sr[`SR_READY] = !busy;
		sr[`SR_ESUSP] = state_reg inside {flash_cmd_pkg::ST_ERS_SUSP,
			flash_cmd_pkg::ST_PES_SETUP, flash_cmd_pkg::ST_PES_BUSY,
			flash_cmd_pkg::ST_PES_SUSP, flash_cmd_pkg::ST_LOCK_SETUP_ES};
		sr[`SR_PSUSP] = state_reg inside {flash_cmd_pkg::ST_PGM_SUSP, flash_cmd_pkg::ST_PES_SUSP};
		sr[`SR_EFP] = state_reg inside {flash_cmd_pkg::ST_EFP_BUSY, flash_cmd_pkg::ST_EFP_VERIFY}
			&& pgm_cnt_reg != 32'h0;
	end

	assign pgm_done  = pgm_run && pgm_cnt_reg == 32'h1;
	assign ers_done  = ers_run && ers_cnt_reg == 32'h1;
	assign ready_out = sr[`SR_READY];
	assign busy_part = (state_reg == flash_cmd_pkg::ST_ERS_BUSY) ? ers_part_reg : act_part_reg;
	assign active_part_out = busy_part;
	assign array_addr_out  = bus.addr;

	// ----------------------------------------
	// Write state machine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		set_err    = 8'h0;
		ld_pgm     = 1'b0;
		ld_ers     = 1'b0;
		ld_efp     = 1'b0;
		lock_act   = 1'b0;
		lock_cmd   = cmd;
		if (wr) begin
			unique case (state_reg)
				flash_cmd_pkg::ST_READY: begin
					unique case (cmd)
						`CMD_PROGRAM, `CMD_PROGRAM_ALT: state_next = flash_cmd_pkg::ST_PGM_SETUP;
						`CMD_ERASE:      state_next = flash_cmd_pkg::ST_ERS_SETUP;
						`CMD_EFP:        state_next = flash_cmd_pkg::ST_EFP_SETUP;
						`CMD_LOCK_SETUP: state_next = flash_cmd_pkg::ST_LOCK_SETUP;
						`CMD_OTP:        state_next = flash_cmd_pkg::ST_OTP_SETUP;
						default: ;
					endcase
				end
				flash_cmd_pkg::ST_LOCK_SETUP, flash_cmd_pkg::ST_LOCK_SETUP_ES: begin
					state_next = (state_reg == flash_cmd_pkg::ST_LOCK_SETUP) ?
						flash_cmd_pkg::ST_READY : flash_cmd_pkg::ST_ERS_SUSP;
					if (cmd inside {`CMD_LOCK, `CMD_CONFIRM, `CMD_LOCKDOWN, `CMD_CFG})
						lock_act = 1'b1;
					else begin
						set_err[`SR_PERR] = 1'b1;
						set_err[`SR_EERR] = 1'b1;
					end
				end
				flash_cmd_pkg::ST_PGM_SETUP, flash_cmd_pkg::ST_PES_SETUP,
				flash_cmd_pkg::ST_OTP_SETUP: begin
					state_next = (state_reg == flash_cmd_pkg::ST_PES_SETUP) ?
						flash_cmd_pkg::ST_ERS_SUSP : flash_cmd_pkg::ST_READY;
					if (!vpp_ok_in) begin
						set_err[`SR_VPP]  = 1'b1;
						set_err[`SR_PERR] = 1'b1;
					end else if (wlocked && state_reg != flash_cmd_pkg::ST_OTP_SETUP) begin
						set_err[`SR_LOCKED] = 1'b1;
						set_err[`SR_PERR]   = 1'b1;
					end else if (state_reg == flash_cmd_pkg::ST_PES_SETUP && wblk == ers_blk_reg)
						set_err[`SR_PERR] = 1'b1;
					else begin
						ld_pgm = 1'b1;
						unique case (state_reg)
							flash_cmd_pkg::ST_PGM_SETUP: state_next = flash_cmd_pkg::ST_PGM_BUSY;
							flash_cmd_pkg::ST_PES_SETUP: state_next = flash_cmd_pkg::ST_PES_BUSY;
							default: state_next = flash_cmd_pkg::ST_OTP_BUSY;
						endcase
					end
				end
				flash_cmd_pkg::ST_ERS_SETUP, flash_cmd_pkg::ST_EFP_SETUP: begin
					state_next = flash_cmd_pkg::ST_READY;
					if (cmd != `CMD_CONFIRM) begin
						set_err[`SR_PERR] = 1'b1;
						set_err[`SR_EERR] = 1'b1;
					end else if (wlocked) begin
						set_err[`SR_LOCKED] = 1'b1;
						set_err[`SR_EERR]   = 1'b1;
					end else if (!vpp_ok_in) begin
						set_err[`SR_VPP]  = 1'b1;
						set_err[`SR_EERR] = 1'b1;
					end else if (state_reg == flash_cmd_pkg::ST_ERS_SETUP) begin
						ld_ers     = 1'b1;
						state_next = flash_cmd_pkg::ST_ERS_BUSY;
					end else begin
						ld_efp     = 1'b1;
						state_next = flash_cmd_pkg::ST_EFP_BUSY;
					end
				end
				flash_cmd_pkg::ST_PGM_BUSY, flash_cmd_pkg::ST_PES_BUSY,
				flash_cmd_pkg::ST_ERS_BUSY: begin
					if (cmd == `CMD_SUSPEND)
						unique case (state_reg)
							flash_cmd_pkg::ST_PGM_BUSY: state_next = flash_cmd_pkg::ST_PGM_SUSP;
							flash_cmd_pkg::ST_PES_BUSY: state_next = flash_cmd_pkg::ST_PES_SUSP;
							default: state_next = flash_cmd_pkg::ST_ERS_SUSP;
						endcase
				end
				flash_cmd_pkg::ST_PGM_SUSP:
					if (cmd == `CMD_CONFIRM) state_next = flash_cmd_pkg::ST_PGM_BUSY;
				flash_cmd_pkg::ST_PES_SUSP:
					if (cmd == `CMD_CONFIRM) state_next = flash_cmd_pkg::ST_PES_BUSY;
				flash_cmd_pkg::ST_ERS_SUSP: begin
					unique case (cmd)
						`CMD_PROGRAM, `CMD_PROGRAM_ALT: state_next = flash_cmd_pkg::ST_PES_SETUP;
						`CMD_LOCK_SETUP: state_next = flash_cmd_pkg::ST_LOCK_SETUP_ES;
						`CMD_CONFIRM:    state_next = flash_cmd_pkg::ST_ERS_BUSY;
						default: ;
					endcase
				end
				flash_cmd_pkg::ST_EFP_BUSY, flash_cmd_pkg::ST_EFP_VERIFY: begin
					if (wblk != efp_blk_reg)
						state_next = (state_reg == flash_cmd_pkg::ST_EFP_BUSY) ?
							flash_cmd_pkg::ST_EFP_VERIFY : flash_cmd_pkg::ST_READY;
					else if (!sr[`SR_EFP])
						ld_pgm = 1'b1;
				end
				flash_cmd_pkg::ST_OTP_BUSY: ;
			endcase
		end
		// Completion beats a same-cycle suspend: the operation is simply over
		if (pgm_done)
			unique case (state_reg)
				flash_cmd_pkg::ST_PGM_BUSY, flash_cmd_pkg::ST_OTP_BUSY:
					state_next = flash_cmd_pkg::ST_READY;
				flash_cmd_pkg::ST_PES_BUSY: state_next = flash_cmd_pkg::ST_ERS_SUSP;
				default: ;
			endcase
		if (ers_done) begin
			state_next = flash_cmd_pkg::ST_READY;
			set_err[`SR_EERR] = erase_fail_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) state_reg <= flash_cmd_pkg::ST_READY;
		else state_reg <= state_next;
	end

	// ----------------------------------------
	// Timers and active operation
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pgm_cnt_reg <= 32'h0;
			ers_cnt_reg <= 32'h0;
		end else begin
			if (ld_pgm) pgm_cnt_reg <= 32'(PROG_CYCLES);
			else if (pgm_run) pgm_cnt_reg <= pgm_cnt_reg - 32'h1;
			if (ld_ers) ers_cnt_reg <= 32'(ERASE_CYCLES);
			else if (ers_run) ers_cnt_reg <= ers_cnt_reg - 32'h1;  // Frozen while suspended
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			act_part_reg <= '0;
			ers_part_reg <= '0;
			ers_blk_reg  <= '0;
			efp_blk_reg  <= '0;
		end else begin
			if (ld_pgm || ld_ers || ld_efp) act_part_reg <= wpart;
			if (ld_ers) begin
				ers_part_reg <= wpart;
				ers_blk_reg  <= wblk;
			end
			if (ld_efp) efp_blk_reg <= wblk;
		end
	end

	// ----------------------------------------
	// Sticky error bits
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) err_reg <= 8'h0;
		else if (wr && cmd == `CMD_CLEAR && state_reg == flash_cmd_pkg::ST_READY)
			err_reg <= set_err;
		else
			err_reg <= err_reg | set_err;
	end

	// ----------------------------------------
	// Block protection
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lock_reg <= {NBLK{`LOCK_RESET}};
			ldn_reg  <= '0;
		end else if (lock_act) begin
			unique case (lock_cmd)
				`CMD_LOCK: lock_reg[wblk] <= 1'b1;
				`CMD_CONFIRM: if (!ldn_reg[wblk]) lock_reg[wblk] <= 1'b0;
				`CMD_LOCKDOWN: begin
					lock_reg[wblk] <= 1'b1;
					ldn_reg[wblk]  <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Output modes
	// ----------------------------------------
	for (genvar p = 0; p < NPART; p++) begin : g_mode
		always_ff @(posedge clk_in) begin
			if (rst_in) mode_reg[p] <= flash_cmd_pkg::MODE_ARRAY;
			else if (wr && wpart == p) begin
				if (state_reg inside {flash_cmd_pkg::ST_PGM_SETUP, flash_cmd_pkg::ST_ERS_SETUP,
					flash_cmd_pkg::ST_OTP_SETUP, flash_cmd_pkg::ST_PES_SETUP,
					flash_cmd_pkg::ST_EFP_SETUP, flash_cmd_pkg::ST_EFP_BUSY,
					flash_cmd_pkg::ST_EFP_VERIFY, flash_cmd_pkg::ST_LOCK_SETUP,
					flash_cmd_pkg::ST_LOCK_SETUP_ES})
					mode_reg[p] <= flash_cmd_pkg::MODE_STATUS;
				else
					unique case (cmd)
						`CMD_READ_ARRAY: mode_reg[p] <= flash_cmd_pkg::MODE_ARRAY;
						`CMD_READ_STATUS, `CMD_PROGRAM, `CMD_PROGRAM_ALT, `CMD_ERASE,
						`CMD_EFP, `CMD_LOCK_SETUP, `CMD_OTP:
							mode_reg[p] <= flash_cmd_pkg::MODE_STATUS;
						`CMD_READ_ID, `CMD_READ_QUERY: mode_reg[p] <= flash_cmd_pkg::MODE_ID;
						default: ;
					endcase
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) rdata_reg <= `ZERO_DATA;
		else if (bus.re)
			unique case (mode_reg[part_of(bus.addr)])
				flash_cmd_pkg::MODE_ARRAY:
					rdata_reg <= (busy && part_of(bus.addr) == busy_part) ?
						`UNDEF_DATA : array_data_in;
				flash_cmd_pkg::MODE_STATUS: rdata_reg <= {8'h0, sr};
				flash_cmd_pkg::MODE_ID:
					unique case (bus.addr[OFS_W-1:0])
						OFS_W'(`ID_MFR_OFS): rdata_reg <= MFR_ID;
						OFS_W'(`ID_DEV_OFS): rdata_reg <= DEV_ID;
						OFS_W'(`ID_BLK_OFS):
							rdata_reg <= {14'h0, ldn_reg[blk_of(bus.addr)],
								lock_reg[blk_of(bus.addr)]};
						default: rdata_reg <= `ZERO_DATA;
					endcase
				default: rdata_reg <= `ZERO_DATA;
			endcase
	end

	assign bus.rdata = rdata_reg;
endmodule : flash_command_state_machine

// [design/flash_cmd_params.svh]
/*
 * Constants of the flash command interpreter: command codes, status bit
 * positions, identifier offsets and operation times.
 * Assumes a 50 MHz clock and a 16-bit data bus.
 */
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_READ_ARRAY  8'hff
`define CMD_PROGRAM     8'h40
`define CMD_PROGRAM_ALT 8'h10
`define CMD_ERASE       8'h20
`define CMD_EFP         8'h30
`define CMD_CONFIRM     8'hd0
`define CMD_SUSPEND     8'hb0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR       8'h50
`define CMD_READ_ID     8'h90
`define CMD_READ_QUERY  8'h98
`define CMD_LOCK_SETUP  8'h60
`define CMD_OTP         8'hc0
`define CMD_LOCK        8'h01
`define CMD_LOCKDOWN    8'h2f
`define CMD_CFG         8'h03

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define SR_READY   7
`define SR_ESUSP   6
`define SR_EERR    5
`define SR_PERR    4
`define SR_VPP     3
`define SR_PSUSP   2
`define SR_LOCKED  1
`define SR_EFP     0

// ----------------------------------------
// Identifier space and fixed data
// ----------------------------------------
`define ID_MFR_OFS     4'h0
`define ID_DEV_OFS     4'h1
`define ID_BLK_OFS     4'h2
`define UNDEF_DATA     16'hffff
`define ZERO_DATA      16'h0000
`define LOCK_RESET     1'b1

// ----------------------------------------
// Times
// ----------------------------------------
`define CLK_PERIOD_NS  20
`define PROG_TIME_NS   16000
`define ERASE_TIME_MS  1000
`define NS_PER_MS      1000000

`endif

// [design/flash_cmd_pkg.sv]
/*
 * Types shared by both ends of the flash command link.
 * Assumes flash_cmd_params.svh supplies the numeric constants.
 */
package flash_cmd_pkg;
	typedef enum logic [4:0] {
		ST_READY, ST_LOCK_SETUP, ST_OTP_SETUP, ST_OTP_BUSY,
		ST_PGM_SETUP, ST_PGM_BUSY, ST_PGM_SUSP,
		ST_ERS_SETUP, ST_ERS_BUSY, ST_ERS_SUSP,
		ST_PES_SETUP, ST_PES_BUSY, ST_PES_SUSP, ST_LOCK_SETUP_ES,
		ST_EFP_SETUP, ST_EFP_BUSY, ST_EFP_VERIFY
	} wsm_state_t;

	typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID} out_mode_t;

	typedef enum logic [3:0] {
		OP_READ, OP_PROGRAM, OP_ERASE, OP_LOCK, OP_SUSPEND,
		OP_RESUME, OP_STATUS, OP_CLEAR, OP_EFP_DATA, OP_RAW
	} host_op_t;

	typedef enum logic [2:0] {H_IDLE, H_CYC1, H_CYC2, H_RD, H_RWAIT, H_DONE} host_state_t;
endpackage : flash_cmd_pkg

// [design/flash_bus_if.sv]
/*
 * Bus between controller and flash: word address, write and read strobes,
 * read data one cycle after the read strobe.
 * Assumes one clock for both ends.
 */
interface flash_bus_if #(parameter int ADDR_W = 9);
	logic [ADDR_W-1:0] addr;
	logic [15:0]       wdata;
	logic [15:0]       rdata;
	logic              we;
	logic              re;

	modport dev  (input addr, input wdata, input we, input re, output rdata);
	modport host (output addr, output wdata, output we, output re, input rdata);
endinterface : flash_bus_if

// [design/flash_cmd_host.sv]
/*
 * Controller end: turns one user operation into the flash bus cycles it
 * needs and polls status where the sequence requires it.
 * Assumes the flash answers reads one cycle after the read strobe.
 */
`include "flash_cmd_params.svh"

module flash_cmd_host #(
	parameter int ADDR_W = 9
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	flash_bus_if.host                  bus,
	input  wire logic                  op_valid_in,
	input  wire flash_cmd_pkg::host_op_t op_in,
	input  wire logic [ADDR_W-1:0]     op_addr_in,
	input  wire logic [15:0]           op_data_in,
	output logic                       op_ready_out,
	output logic                       done_out,
	output logic [15:0]                result_out
);
	if (ADDR_W < 1) $error("flash_cmd_host: bad ADDR_W");

	flash_cmd_pkg::host_state_t state_reg;
	flash_cmd_pkg::host_op_t    op_reg;
	logic [ADDR_W-1:0]          addr_reg;
	logic [15:0]                w1_reg, w2_reg, result_reg;
	logic                       two_reg, rd_reg, poll_reg;

	assign op_ready_out = state_reg == flash_cmd_pkg::H_IDLE;
	assign done_out     = state_reg == flash_cmd_pkg::H_DONE;
	assign result_out   = result_reg;
	assign bus.addr     = addr_reg;
	assign bus.we       = state_reg inside {flash_cmd_pkg::H_CYC1, flash_cmd_pkg::H_CYC2};
	assign bus.re       = state_reg == flash_cmd_pkg::H_RD;
	assign bus.wdata    = (state_reg == flash_cmd_pkg::H_CYC2) ? w2_reg : w1_reg;

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg  <= flash_cmd_pkg::H_IDLE;
			op_reg     <= flash_cmd_pkg::OP_RAW;
			addr_reg   <= '0;
			w1_reg     <= 16'h0;
			w2_reg     <= 16'h0;
			two_reg    <= 1'b0;
			rd_reg     <= 1'b0;
			poll_reg   <= 1'b0;
			result_reg <= 16'h0;
		end else begin
			unique case (state_reg)
				flash_cmd_pkg::H_IDLE:
					if (op_valid_in) begin
						op_reg   <= op_in;
						addr_reg <= op_addr_in;
						w2_reg   <= op_data_in;
						two_reg  <= 1'b0;
						rd_reg   <= 1'b0;
						poll_reg <= 1'b0;
						state_reg <= flash_cmd_pkg::H_CYC1;
						unique case (op_in)
							flash_cmd_pkg::OP_READ: begin
								rd_reg    <= 1'b1;
								state_reg <= flash_cmd_pkg::H_RD;
							end
							flash_cmd_pkg::OP_PROGRAM: begin
								w1_reg  <= {8'h0, `CMD_PROGRAM};
								two_reg <= 1'b1;
							end
							flash_cmd_pkg::OP_ERASE: begin
								w1_reg  <= {8'h0, `CMD_ERASE};
								w2_reg  <= {8'h0, `CMD_CONFIRM};
								two_reg <= 1'b1;
							end
							flash_cmd_pkg::OP_LOCK: begin
								w1_reg  <= {8'h0, `CMD_LOCK_SETUP};
								w2_reg  <= {8'h0, op_data_in[7:0]};
								two_reg <= 1'b1;
							end
							flash_cmd_pkg::OP_SUSPEND: begin
								w1_reg   <= {8'h0, `CMD_SUSPEND};
								w2_reg   <= {8'h0, `CMD_READ_STATUS};
								two_reg  <= 1'b1;
								rd_reg   <= 1'b1;
								poll_reg <= 1'b1;
							end
							flash_cmd_pkg::OP_RESUME: w1_reg <= {8'h0, `CMD_CONFIRM};
							flash_cmd_pkg::OP_STATUS: begin
								w1_reg <= {8'h0, `CMD_READ_STATUS};
								rd_reg <= 1'b1;
							end
							flash_cmd_pkg::OP_CLEAR: w1_reg <= {8'h0, `CMD_CLEAR};
							flash_cmd_pkg::OP_EFP_DATA: begin
								w1_reg    <= op_data_in;
								rd_reg    <= 1'b1;
								state_reg <= flash_cmd_pkg::H_RD;
							end
							flash_cmd_pkg::OP_RAW: w1_reg <= op_data_in;
						endcase
					end
				flash_cmd_pkg::H_CYC1:
					if (two_reg) state_reg <= flash_cmd_pkg::H_CYC2;
					else if (rd_reg && op_reg != flash_cmd_pkg::OP_EFP_DATA)
						state_reg <= flash_cmd_pkg::H_RD;
					else state_reg <= flash_cmd_pkg::H_DONE;
				flash_cmd_pkg::H_CYC2:
					state_reg <= rd_reg ? flash_cmd_pkg::H_RD : flash_cmd_pkg::H_DONE;
				flash_cmd_pkg::H_RD: state_reg <= flash_cmd_pkg::H_RWAIT;
				flash_cmd_pkg::H_RWAIT: begin
					result_reg <= bus.rdata;
					if (poll_reg && !bus.rdata[`SR_READY])
						state_reg <= flash_cmd_pkg::H_RD;
					else if (op_reg == flash_cmd_pkg::OP_EFP_DATA)
						state_reg <= bus.rdata[`SR_EFP] ?
							flash_cmd_pkg::H_RD : flash_cmd_pkg::H_CYC1;
					else state_reg <= flash_cmd_pkg::H_DONE;
				end
				flash_cmd_pkg::H_DONE: state_reg <= flash_cmd_pkg::H_IDLE;
			endcase
		end
	end
endmodule : flash_cmd_host

// [sim/flash_cmd_asserts.sv]
/* Checks on the flash command bus: two-cycle pairing, suspend polling,
   read data timing, status and lock flag reads.
   Assumes one clock, synchronous active-high reset, addr = {blk, ofs}. */
module flash_cmd_asserts (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [8:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        we,
	input wire logic        re
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cmd_reg;
	logic [8:0] at_reg;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Last write decides the mode of the partition it hit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cmd_reg <= 8'hff;
			at_reg <= 9'h000;
		end else if (we) begin
			cmd_reg <= wdata[7:0];
			at_reg <= addr;
		end
	end
	// ----------
	// Properties
	// ----------
	property p_pair;
		we ##1 we |-> $stable(addr) ##1 !we;
	endproperty
	a_pair: assert property (p_pair) else $error("split pair");
	property p_erase;
		we && wdata[7:0] == 8'h20 ##1 we |-> wdata[7:0] == 8'hd0;
	endproperty
	a_erase: assert property (p_erase) else $error("bad erase confirm");
	property p_lock;
		we && wdata[7:0] == 8'h60 ##1 we |-> wdata[7:0] inside {8'h01, 8'hd0, 8'h2f};
	endproperty
	a_lock: assert property (p_lock) else $error("bad lock confirm");
	property p_suspend;
		we && wdata[7:0] == 8'hb0 |=> we && wdata[7:0] == 8'h70 && $stable(addr);
	endproperty
	a_suspend: assert property (p_suspend) else $error("no status after suspend");
	property p_status;
		re && cmd_reg == 8'h70 && addr[8:7] == at_reg[8:7] |=> rdata[15:8] == 8'h00;
	endproperty
	a_status: assert property (p_status) else $error("status high byte");
	property p_flags;
		re && cmd_reg == 8'h90 && addr == at_reg + 9'h002 |=> rdata[15:2] == 14'h0000;
	endproperty
	a_flags: assert property (p_flags) else $error("lock flag bits");
	property p_hold;
		!re |=> $stable(rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_reset;
		$fell(rst_in) |-> !we && !re && rdata == 16'h0000;
	endproperty
	a_reset: assert property (p_reset) else $error("not quiet after reset");
endmodule : flash_cmd_asserts

// [sim/flash_command_state_machine_tb.sv]
/* Bench: host end and flash end joined by the bus, checked by a model.
   Assumes the design files and the checker are compiled first. */
module flash_command_state_machine_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    clk_in;
	logic                    rst_in;
	logic                    op_valid;
	flash_cmd_pkg::host_op_t op;
	logic [8:0]              op_addr;
	logic [15:0]             op_data;
	logic                    done;
	logic                    op_ready;
	logic [15:0]             result;
	logic                    vpp_ok;
	logic                    erase_fail;
	logic [8:0]              arr_addr;
	logic                    ready;
	logic [1:0]              part;
	int                      n_errors = 0;
	int                      n_tests = 0;
	int                      seed = 32'h2e3d595b;
	int                      lk[32];
	int                      err = 0;
	logic [8:0]              a;
	logic [7:0]              cd[4] = '{8'hd0, 8'h01, 8'hd0, 8'h2f};
	flash_bus_if #(.ADDR_W(9)) link ();
	flash_cmd_host #(.ADDR_W(9)) i_flash_cmd_host (.clk_in(clk_in), .rst_in(rst_in), .bus(link),
		.op_valid_in(op_valid), .op_in(op), .op_addr_in(op_addr), .op_data_in(op_data),
		.op_ready_out(op_ready), .done_out(done), .result_out(result));
	// MFR_ID value is arbitrary
	flash_command_state_machine #(.PROG_CYCLES(8), .ERASE_CYCLES(80), .MFR_ID(16'h1234))
		i_flash_command_state_machine (.clk_in(clk_in), .rst_in(rst_in), .bus(link),
		.vpp_ok_in(vpp_ok), .erase_fail_in(erase_fail), .array_data_in(arr(arr_addr)),
		.array_addr_out(arr_addr), .ready_out(ready), .active_part_out(part));
	flash_cmd_asserts i_flash_cmd_asserts (.clk_in(clk_in), .rst_in(rst_in), .addr(link.addr),
		.wdata(link.wdata), .rdata(link.rdata), .we(link.we), .re(link.re));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	function automatic logic [8:0] ba(input int b);
		return 9'(b * 16);
	endfunction : ba
	function automatic logic [15:0] arr(input logic [8:0] x);
		return {7'h00, x} ^ 16'h3c00;
	endfunction : arr
	function automatic logic [15:0] sr(input bit busy);
		return 16'(busy ? err : err | 128);
	endfunction : sr
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic run(input flash_cmd_pkg::host_op_t o, input logic [8:0] x, input logic [15:0] d);
		int k;
		@(posedge clk_in);
		op_valid <= 1'b1;
		op <= o;
		op_addr <= x;
		op_data <= d;
		@(negedge clk_in);
		chk("op ready", 16'h0001, {15'h0000, op_ready});
		@(posedge clk_in);
		op_valid <= 1'b0;
		for (k = 0; k < 99; k++) begin
			@(negedge clk_in);
			if (done === 1'b1)
				break;
		end
		if (k == 99) begin
			n_errors++;
			wrap_up();
		end
	endtask : run
	task automatic raw(input int b, input logic [7:0] c);
		run(flash_cmd_pkg::OP_RAW, ba(b), {8'h00, c});
	endtask : raw
	task automatic rd(input logic [8:0] x, input logic [15:0] e);
		run(flash_cmd_pkg::OP_READ, x, 16'h0000);
		chk("read", e, result);
	endtask : rd
	// Polls until ready; caller compares the last status seen
	task automatic poll(input int b);
		for (int k = 0; k < 40; k++) begin
			run(flash_cmd_pkg::OP_STATUS, ba(b), 16'h0000);
			if (result[7] === 1'b1)
				break;
		end
		if (result[7] !== 1'b1) begin
			n_errors++;
			wrap_up();
		end
	endtask : poll
	task automatic lock(input int b, input logic [7:0] c);
		run(flash_cmd_pkg::OP_LOCK, ba(b), {8'h00, c});
		if (lk[b] < 2)
			lk[b] = (c == 8'h01) ? 1 : (c == 8'hd0) ? 0 : 3;
	endtask : lock
	task automatic flags(input int b);
		raw(b, 8'h90);
		rd(ba(b) + 9'h002, 16'(lk[b]));
	endtask : flags
	task automatic clr;
		run(flash_cmd_pkg::OP_CLEAR, ba(0), 16'h0000);
		err = 0;
	endtask : clr
	initial begin
		rst_in = 1'b1;
		op_valid = 1'b0;
		op = flash_cmd_pkg::OP_READ;
		op_addr = 9'h000;
		op_data = 16'h0000;
		vpp_ok = 1'b1;
		erase_fail = 1'b0;
		foreach (lk[i])
			lk[i] = 1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			a = 9'($random(seed));
			rd(a, arr(a));
		end
		raw(9, 8'h90);
		rd(ba(9), 16'h1234);
		flags(9);
		rd(ba(9) + 9'h002, 16'h0001);
		rd(ba(17) + 9'h005, arr(ba(17) + 9'h005));
		foreach (cd[i]) begin
			lock(13, cd[i]);
			poll(13);
			chk("lock status", sr(0), result);
			flags(13);
		end
		$display("test modes done");
		lock(12, 8'hd0);
		run(flash_cmd_pkg::OP_ERASE, ba(12), 16'h0000);
		chk("part", 16'h0001, {14'h0000, part});
		chk("ready", 16'h0000, {15'h0000, ready});
		run(flash_cmd_pkg::OP_LOCK, ba(6), 16'h00d0);
		raw(12, 8'hff);
		rd(ba(12) + 9'h001, 16'hffff);
		poll(12);
		chk("ready", 16'h0001, {15'h0000, ready});
		flags(6);
		$display("test erase done");
		run(flash_cmd_pkg::OP_ERASE, ba(7), 16'h0000);
		err = 8'h22;
		poll(7);
		chk("status", sr(0), result);
		poll(7);
		chk("status", sr(0), result);
		clr();
		@(posedge clk_in) vpp_ok <= 1'b0;
		run(flash_cmd_pkg::OP_PROGRAM, ba(12) + 9'h003, 16'h5a5a);
		err = 8'h18;
		poll(12);
		chk("status", sr(0), result);
		clr();
		poll(12);
		chk("status", sr(0), result);
		@(posedge clk_in) vpp_ok <= 1'b1;
		$display("test errors done");
		run(flash_cmd_pkg::OP_ERASE, ba(12), 16'h0000);
		run(flash_cmd_pkg::OP_SUSPEND, ba(12), 16'h0000);
		chk("suspend", 16'h00c0, result);
		raw(9, 8'hff);
		rd(ba(9) + 9'h004, arr(ba(9) + 9'h004));
		@(posedge clk_in) erase_fail <= 1'b1;
		run(flash_cmd_pkg::OP_RESUME, ba(30), 16'h0000);
		run(flash_cmd_pkg::OP_STATUS, ba(12), 16'h0000);
		chk("resume", sr(1), result);
		err = 8'h20;
		poll(12);
		chk("status", sr(0), result);
		clr();
		raw(12, 8'h20);
		raw(12, 8'h55);
		err = 8'h30;
		poll(12);
		chk("status", sr(0), result);
		$display("test suspend done");
		run(flash_cmd_pkg::OP_ERASE, ba(12), 16'h0000);
		raw(12, 8'h50);
		poll(12);
		chk("status", sr(0), result);
		raw(12, 8'h30);
		raw(12, 8'hd0);
		chk("ready", 16'h0000, {15'h0000, ready});
		run(flash_cmd_pkg::OP_EFP_DATA, ba(12) + 9'h001, 16'h1234);
		run(flash_cmd_pkg::OP_EFP_DATA, ba(12) + 9'h002, 16'h4321);
		chk("efp status", sr(1), result);
		raw(13, 8'hff);
		chk("ready", 16'h0000, {15'h0000, ready});
		raw(13, 8'hff);
		chk("ready", 16'h0001, {15'h0000, ready});
		$display("test efp done");
		wrap_up();
	end
endmodule : flash_command_state_machine_tb
